/* File: src/elx_unit.sv */
// Behaviour
// - Seventeen interrupt lines exist: lines 0 to 15 each take their pin from port group A to G, line 16 takes the supply level detector.
// - Port group H pins can never reach a line nor raise a request.
// - Each line is enabled on its own and a disabled line raises no request.
// - Each line triggers on rising, falling or both edges as selected.
// - A pending register holds one flag per line, set by that line's enabled trigger.
// - Level changes shorter than one clock period are still caught.
// - An edge on an enabled line raises an interrupt request, an event request or both.
// - Any configured line, the supply level detector among them, wakes the processor.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module elx_unit (
    // Clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_b,
    // Register port
    input  wire elx_pkg::elx_bus_req_s i_bus,
    output logic [elx_pkg::DATA_W-1:0] o_rdata,
    // Line sources
    input  wire elx_pkg::elx_pins_t    i_port_pins,
    input  wire logic                  i_supply_level_detector,
    // Requests toward the processor
    output logic                       o_irq,
    output elx_pkg::elx_line_t         o_event,
    output logic                       o_wake
);
    import elx_pkg::*;

    elx_cfg_s                  cfg_reg;
    elx_cfg_s                  cfg_next;
    elx_src_t [NUM_PINS-1:0]   src_reg;
    elx_src_t [NUM_PINS-1:0]   src_next;
    elx_line_t                 pending_reg;
    elx_line_t                 pending_next;
    elx_line_t                 event_reg;
    elx_line_t                 event_next;
    logic                      irq_reg;
    logic                      irq_next;
    logic                      wake_reg;
    logic                      wake_next;
    logic [DATA_W-1:0]         rdata_reg;
    logic [DATA_W-1:0]         rdata_next;

    elx_line_t                 line_in;
    elx_line_t                 line_edge;
    elx_line_t                 line_enabled;
    elx_line_t                 line_set;
    elx_line_t                 clear_mask;
    elx_line_t                 evt_cause;
    logic                      irq_cause;
    logic                      addr_hit;
    logic [NUM_PINS-1:0]       src_is_h;

    // Line source selection and edge detection
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
            if (gi < NUM_PINS) begin : g_pin
                assign src_is_h[gi] = (src_reg[gi] == GROUP_H);
                // Group H code parks the line at a steady low
                assign line_in[gi]  = src_is_h[gi] ? 1'b0 : i_port_pins[src_reg[gi]][gi];
            end else begin : g_supply
                assign line_in[gi]  = i_supply_level_detector;
            end
            elx_edge_cell u_cell (
                .i_clock   (i_clock),
                .i_rst_b   (i_rst_b),
                .i_line    (line_in[gi]),
                .i_rise_en (cfg_reg.rise_en[gi]),
                .i_fall_en (cfg_reg.fall_en[gi]),
                .o_edge    (line_edge[gi])
            );
        end
    endgenerate

    // Request generation
    always_comb begin
        line_enabled = cfg_reg.irq_mask | cfg_reg.evt_mask;
        line_set     = line_edge & line_enabled;
        evt_cause    = line_edge & cfg_reg.evt_mask;
        irq_cause    = |(pending_reg & cfg_reg.irq_mask);
    end

    // Register writes
    always_comb begin
        cfg_next   = cfg_reg;
        src_next   = src_reg;
        clear_mask = RST_LINES;
        if (i_bus.wr) begin
            case (i_bus.addr)
                OFF_IRQ_MASK: begin
                    cfg_next.irq_mask = i_bus.wdata[NUM_LINES-1:0];
                end
                OFF_EVT_MASK: begin
                    cfg_next.evt_mask = i_bus.wdata[NUM_LINES-1:0];
                end
                OFF_RISE_EN: begin
                    cfg_next.rise_en = i_bus.wdata[NUM_LINES-1:0];
                end
                OFF_FALL_EN: begin
                    cfg_next.fall_en = i_bus.wdata[NUM_LINES-1:0];
                end
                OFF_PENDING: begin
                    clear_mask = i_bus.wdata[NUM_LINES-1:0];
                end
                OFF_SRC_LO: begin
                    for (int j = 0; j < SRC_PER_REG; j++) begin
                        src_next[j] = i_bus.wdata[j*SRC_FIELD_STRIDE +: SEL_W];
                    end
                end
                OFF_SRC_HI: begin
                    for (int j = 0; j < SRC_PER_REG; j++) begin
                        src_next[j+SRC_PER_REG] = i_bus.wdata[j*SRC_FIELD_STRIDE +: SEL_W];
                    end
                end
                default: begin
                    cfg_next = cfg_reg;
                end
            endcase
        end
    end

    // Pending flags: a new edge wins over a clear in the same cycle
    always_comb begin
        pending_next = (pending_reg & ~clear_mask) | line_set;
        event_next   = evt_cause;
        irq_next     = irq_cause;
        wake_next    = irq_cause | (|evt_cause);
    end

    // Register reads, data stand one cycle after the strobe
    always_comb begin
        rdata_next = '0;
        addr_hit   = 1'b1;
        case (i_bus.addr)
            OFF_IRQ_MASK: rdata_next = DATA_W'(cfg_reg.irq_mask);
            OFF_EVT_MASK: rdata_next = DATA_W'(cfg_reg.evt_mask);
            OFF_RISE_EN:  rdata_next = DATA_W'(cfg_reg.rise_en);
            OFF_FALL_EN:  rdata_next = DATA_W'(cfg_reg.fall_en);
            OFF_PENDING:  rdata_next = DATA_W'(pending_reg);
            OFF_SRC_LO: begin
                for (int j = 0; j < SRC_PER_REG; j++) begin
                    rdata_next[j*SRC_FIELD_STRIDE +: SEL_W] = src_reg[j];
                end
            end
            OFF_SRC_HI: begin
                for (int j = 0; j < SRC_PER_REG; j++) begin
                    rdata_next[j*SRC_FIELD_STRIDE +: SEL_W] = src_reg[j+SRC_PER_REG];
                end
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
        if (!i_bus.rd) begin
            rdata_next = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            cfg_reg     <= RST_CFG;
            src_reg     <= {NUM_PINS{RST_SRC}};
            pending_reg <= RST_LINES;
            event_reg   <= RST_LINES;
            irq_reg     <= 1'b0;
            wake_reg    <= 1'b0;
            rdata_reg   <= '0;
        end else begin
            cfg_reg     <= cfg_next;
            src_reg     <= src_next;
            pending_reg <= pending_next;
            event_reg   <= event_next;
            irq_reg     <= irq_next;
            wake_reg    <= wake_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_irq   = irq_reg;
    assign o_event = event_reg;
    assign o_wake  = wake_reg;

    // Checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_line_fires;
        line_set != '0;
    endsequence

    sequence s_irq_line_fires;
        (line_set & cfg_reg.irq_mask) != '0;
    endsequence

    sequence s_clear_write;
        i_bus.wr && (i_bus.addr == OFF_PENDING);
    endsequence

    sequence s_pending_read;
        i_bus.rd && (i_bus.addr == OFF_PENDING);
    endsequence

    sequence s_mask_write;
        i_bus.wr && (i_bus.addr == OFF_IRQ_MASK);
    endsequence

    sequence s_src_write;
        i_bus.wr && (i_bus.addr == OFF_SRC_LO);
    endsequence

    property p_flag_set;
        s_line_fires |=> ((pending_reg & $past(line_set)) == $past(line_set));
    endproperty

    property p_clear_lands;
        s_clear_write |=> ((pending_reg & $past(clear_mask) & ~$past(line_set)) == '0);
    endproperty

    property p_irq_chain;
        s_irq_line_fires |-> ##2 o_irq;
    endproperty

    pend_set_a:
        assert property (p_flag_set)
            else $error("pending flag missed an enabled edge");

    disabled_quiet_a:
        assert property ((pending_reg & ~$past(pending_reg) & ~$past(line_enabled)) == '0)
            else $error("disabled line set a pending flag");

    pend_hold_a:
        assert property ((~pending_reg & $past(pending_reg) & ~$past(clear_mask)) == '0)
            else $error("pending flag dropped without a clear");

    w1c_clear_a:
        assert property (p_clear_lands)
            else $error("write of one did not clear the flag");

    irq_chain_a:
        assert property (p_irq_chain)
            else $error("edge on an irq line gave no interrupt two cycles later");

    irq_follow_a:
        assert property (1'b1 |=> (o_irq == $past(irq_cause)))
            else $error("interrupt output does not follow masked pending");

    event_pulse_a:
        assert property ((evt_cause != '0) |=> (o_event == $past(evt_cause))
                         ##1 ((o_event & $past(o_event) & ~$past(line_edge)) == '0))
            else $error("event pulse wrong");

    event_mask_a:
        assert property (1'b1 |=> ((o_event & ~$past(cfg_reg.evt_mask)) == '0))
            else $error("event pulse on a line without event enable");

    wake_event_a:
        assert property ((evt_cause != '0) |=> o_wake)
            else $error("event gave no wake");

    trig_select_a:
        assert property ((line_set & ~(cfg_reg.rise_en | cfg_reg.fall_en)) == '0)
            else $error("request from a line with no trigger selected");

    enable_write_a:
        assert property (s_mask_write |=>
                         (cfg_reg.irq_mask == $past(i_bus.wdata[NUM_LINES-1:0])))
            else $error("interrupt enable write did not land");

    src_write_a:
        assert property (s_src_write |=> (src_reg[0] == $past(i_bus.wdata[SEL_W-1:0])))
            else $error("source select write did not land");

    unmapped_hold_a:
        assert property ((i_bus.wr && !addr_hit) |=> (cfg_reg == $past(cfg_reg)))
            else $error("write to an unmapped address changed the setup");

    wake_level_a:
        assert property (o_irq |-> o_wake)
            else $error("interrupt without wake");

    read_pend_a:
        assert property (s_pending_read |=> (o_rdata[NUM_LINES-1:0] == $past(pending_reg)))
            else $error("pending read returned wrong data");

    read_idle_a:
        assert property ((!i_bus.rd || !addr_hit) |=> (o_rdata == '0))
            else $error("read data not zero outside a mapped read");

    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_chk
            group_h_a:
                assert property ((src_is_h[gi])[*6] |-> !line_set[gi])
                    else $error("group H source raised a request");
        end
    endgenerate

endmodule

/* File: src/elx_pkg.sv */
package elx_pkg;

    // Sizes
    localparam int NUM_PINS    = 16;
    localparam int NUM_GROUPS  = 8;
    localparam int NUM_LINES   = 17;
    localparam int SUPPLY_LINE = 16;
    localparam int SEL_W       = 3;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;

    // Source select layout: one nibble per line, eight lines per register
    localparam int SRC_FIELD_STRIDE = 4;
    localparam int SRC_PER_REG      = 8;

    // Port group codes; group H never feeds a line
    localparam logic [SEL_W-1:0] GROUP_A = 3'h0;
    localparam logic [SEL_W-1:0] GROUP_H = 3'h7;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RISE_EN  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FALL_EN  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PENDING  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SRC_LO   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SRC_HI   = 8'h18;

    // Types
    typedef logic [NUM_LINES-1:0]                 elx_line_t;
    typedef logic [SEL_W-1:0]                     elx_src_t;
    typedef logic [NUM_GROUPS-1:0][NUM_PINS-1:0]  elx_pins_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } elx_bus_req_s;

    typedef struct packed {
        elx_line_t irq_mask;
        elx_line_t evt_mask;
        elx_line_t rise_en;
        elx_line_t fall_en;
    } elx_cfg_s;

    // Reset values
    localparam elx_line_t RST_LINES = 17'h00000;
    localparam elx_src_t  RST_SRC   = GROUP_A;
    localparam elx_cfg_s  RST_CFG   = '{RST_LINES, RST_LINES, RST_LINES, RST_LINES};

endpackage

/* File: src/elx_edge_cell.sv */
`timescale 1ns/1ns
module elx_edge_cell (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    // Line and trigger selection
    input  wire logic i_line,
    input  wire logic i_rise_en,
    input  wire logic i_fall_en,
    // Detected edge, one cycle
    output logic      o_edge
);
    import elx_pkg::*;

    logic       rise_tog_reg;
    logic       rise_tog_next;
    logic       fall_tog_reg;
    logic       fall_tog_next;
    logic [1:0] meta_reg;
    logic [1:0] meta_next;
    logic [1:0] sync_reg;
    logic [1:0] sync_next;
    logic [1:0] last_reg;
    logic [1:0] last_next;
    logic [1:0] changed;

    always_comb begin
        rise_tog_next = ~rise_tog_reg;
        fall_tog_next = ~fall_tog_reg;
    end

    // Catchers clocked by the line itself: pulses narrower than a clock still toggle them
    always_ff @(posedge i_line or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rise_tog_reg <= 1'b0;
        end else begin
            rise_tog_reg <= rise_tog_next;
        end
    end

    always_ff @(negedge i_line or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fall_tog_reg <= 1'b0;
        end else begin
            fall_tog_reg <= fall_tog_next;
        end
    end

    // Toggle crossing into the clock domain
    always_comb begin
        meta_next = {fall_tog_reg, rise_tog_reg};
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            meta_reg <= 2'h0;
            sync_reg <= 2'h0;
            last_reg <= 2'h0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    assign changed = sync_reg ^ last_reg;
    assign o_edge  = (changed[0] & i_rise_en) | (changed[1] & i_fall_en);

endmodule

/* File: sim/elx_line_model.sv */
`timescale 1ns/1ns
module elx_line_model (
    // Clock
    input  wire logic               i_clock,
    // Observed requests
    input  wire elx_pkg::elx_line_t i_event,
    input  wire logic               i_wake,
    // Driven line sources
    output elx_pkg::elx_pins_t      o_pins,
    output logic                    o_supply
);
    import elx_pkg::*;

    elx_line_t  evt_seen;
    logic       wake_seen;
    logic [7:0] evt_pulses;

    initial begin
        o_pins    = '0;
        o_supply  = 1'b0;
        evt_seen  = '0;
        wake_seen = 1'b0;
        evt_pulses = 8'h00;
    end

    // Keeps one-cycle pulses until the bench clears them
    always @(posedge i_clock) begin
        evt_seen  <= evt_seen | i_event;
        wake_seen <= wake_seen | i_wake;
        if (i_event != '0) begin
            evt_pulses <= evt_pulses + 8'h01;
        end
    end

    // Clears between edges so the sticky capture cannot write the old value back
    task automatic clear_seen();
        @(negedge i_clock);
        evt_seen   = '0;
        wake_seen  = 1'b0;
        evt_pulses = 8'h00;
        @(posedge i_clock);
    endtask

    // Group code NUM_GROUPS stands for the supply level detector
    task automatic set_pin(input int g, input int p, input logic v);
        #1;
        if (g == NUM_GROUPS) begin
            o_supply = v;
        end else begin
            o_pins[g][p] = v;
        end
    endtask

    // Pulse far shorter than one clock period
    task automatic glitch(input int g, input int p);
        #1 o_pins[g][p] = ~o_pins[g][p];
        #1 o_pins[g][p] = ~o_pins[g][p];
    endtask
endmodule

/* File: sim/elx_unit_test.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module elx_unit_test;
    import elx_pkg::*;

    logic         i_clock   = 1'b0;
    logic         i_rst_b   = 1'b0;
    elx_bus_req_s bus       = '0;
    logic [31:0]  rdata;
    elx_pins_t    pins;
    logic         supply;
    logic         irq;
    elx_line_t    evt;
    logic         wake;
    int           bad_count = 0;
    int           n_checks  = 0;
    int           cycles    = 0;
    logic [7:0]   offs[7]   = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};

    always #2 i_clock = ~i_clock;

    elx_unit dut_u (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(rdata),
        .i_port_pins(pins), .i_supply_level_detector(supply), .o_irq(irq),
        .o_event(evt), .o_wake(wake));

    elx_line_model line_u (.i_clock(i_clock), .i_event(evt), .i_wake(wake),
        .o_pins(pins), .o_supply(supply));

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        bus <= elx_bus_req_s'{a, d, 1'b1, 1'b0};
        @(posedge i_clock);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        bus <= elx_bus_req_s'{a, 32'h0, 1'b0, 1'b1};
        @(posedge i_clock);
        bus.rd <= 1'b0;
        #1 `CHK(rdata, exp)
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic cfg(input elx_line_t im, em, re, fe);
        wr(OFF_IRQ_MASK, {15'h0, im});
        wr(OFF_EVT_MASK, {15'h0, em});
        wr(OFF_RISE_EN, {15'h0, re});
        wr(OFF_FALL_EN, {15'h0, fe});
        wr(OFF_PENDING, 32'h0001FFFF);
        line_u.clear_seen();
    endtask

    initial begin
        repeat (16) @(posedge i_clock);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(offs[i], 32'h0);
        rd_chk(8'h1C, 32'h0);
        wr(OFF_IRQ_MASK, 32'hFFFFFFFF);
        rd_chk(OFF_IRQ_MASK, 32'h0001FFFF);
        wr(8'h1C, 32'h0);
        rd_chk(OFF_IRQ_MASK, 32'h0001FFFF);
        wr(OFF_SRC_LO, 32'hFFFFFFFF);
        rd_chk(OFF_SRC_LO, 32'h77777777);
        wr(OFF_SRC_LO, 32'h0);
        $display("Test registers done");
        // Rise only, fall only, both
        for (int m = 1; m < 4; m++) begin
            cfg(17'h1, 17'h0, {16'h0, m[0]}, {16'h0, m[1]});
            line_u.set_pin(0, 0, 1'b1);
            wait_n(6);
            rd_chk(OFF_PENDING, {31'h0, m[0]});
            `CHK(irq, m[0])
            wr(OFF_PENDING, 32'h1);
            wait_n(3);
            `CHK(irq, 1'b0)
            line_u.set_pin(0, 0, 1'b0);
            wait_n(6);
            rd_chk(OFF_PENDING, {31'h0, m[1]});
            wr(OFF_PENDING, 32'h1);
        end
        $display("Test trigger modes done");
        cfg(17'h0, 17'h0, 17'h2, 17'h2);
        line_u.set_pin(0, 1, 1'b1);
        wait_n(6);
        rd_chk(OFF_PENDING, 32'h0);
        cfg(17'h202, 17'h0, 17'h202, 17'h0);
        wr(OFF_SRC_LO, 32'h00000070);
        wr(OFF_SRC_HI, 32'h00000060);
        wr(OFF_PENDING, 32'h0001FFFF);
        line_u.set_pin(7, 1, 1'b1);
        line_u.set_pin(6, 9, 1'b1);
        wait_n(6);
        rd_chk(OFF_PENDING, 32'h00000200);
        $display("Test sources done");
        cfg(17'h4, 17'h4, 17'h4, 17'h4);
        line_u.glitch(0, 2);
        wait_n(6);
        rd_chk(OFF_PENDING, 32'h00000004);
        `CHK(line_u.evt_seen, 17'h00004)
        `CHK(line_u.evt_pulses, 8'h01)
        $display("Test short pulse done");
        cfg(17'h0, 17'h10000, 17'h10000, 17'h0);
        line_u.set_pin(NUM_GROUPS, 0, 1'b1);
        wait_n(6);
        `CHK(line_u.evt_seen, 17'h10000)
        `CHK(line_u.evt_pulses, 8'h01)
        `CHK(line_u.wake_seen, 1'b1)
        `CHK(irq, 1'b0)
        rd_chk(OFF_PENDING, 32'h00010000);
        $display("Test events done");
        report_and_stop();
    end
endmodule
